// file: rtl/auto_low_limit_adjust_defs.vh
`ifndef AUTO_LOW_LIMIT_ADJUST_DEFS_VH
`define AUTO_LOW_LIMIT_ADJUST_DEFS_VH
`define AUTO_LOW_LIMIT_ADJUST_ADDR_STEP_REM 8'hb4
`define AUTO_LOW_LIMIT_ADJUST_ADDR_STEP_AMB 8'hb5
`define AUTO_LOW_LIMIT_ADJUST_ADDR_DLY_REM 8'hb6
`define AUTO_LOW_LIMIT_ADJUST_ADDR_ENABLE 8'hb7
`define AUTO_LOW_LIMIT_ADJUST_ADDR_STATUS 8'hb8
`define AUTO_LOW_LIMIT_ADJUST_ADDR_RSV_RW 8'hba
`define AUTO_LOW_LIMIT_ADJUST_ADDR_RSV_RO_A 8'hbb
`define AUTO_LOW_LIMIT_ADJUST_ADDR_RSV_RO_B 8'hbd
`define AUTO_LOW_LIMIT_ADJUST_ADDR_TOP_Z1 8'hae
`define AUTO_LOW_LIMIT_ADJUST_ADDR_TOP_Z3 8'haf
`define AUTO_LOW_LIMIT_ADJUST_ADDR_TOP_Z2 8'hb3
`define AUTO_LOW_LIMIT_ADJUST_ADDR_CTRL 8'hf0
`define AUTO_LOW_LIMIT_ADJUST_RST_RSV_RW 8'h03
`define AUTO_LOW_LIMIT_ADJUST_RST_TOP 8'h2d
`define AUTO_LOW_LIMIT_ADJUST_EN_TOPINT 0
`define AUTO_LOW_LIMIT_ADJUST_EN_Z2 1
`define AUTO_LOW_LIMIT_ADJUST_EN_Z1 2
`define AUTO_LOW_LIMIT_ADJUST_EN_Z3 3
`define AUTO_LOW_LIMIT_ADJUST_ST_Z2 0
`define AUTO_LOW_LIMIT_ADJUST_ST_Z1 1
`define AUTO_LOW_LIMIT_ADJUST_ST_Z3 2
`define AUTO_LOW_LIMIT_ADJUST_CTRL_LOCK 0
`define AUTO_LOW_LIMIT_ADJUST_CTRL_GIE 1
`define AUTO_LOW_LIMIT_ADJUST_CLK_HZ 200000000
`define AUTO_LOW_LIMIT_ADJUST_MINUTE_S 60
`define AUTO_LOW_LIMIT_ADJUST_MINUTE_CYC 36'd12000000000
`endif

// file: rtl/auto_low_limit_adjust_tick.v
`timescale 1ns/100ps
// One-cycle enable pulse every PERIOD cycles
module auto_low_limit_adjust_tick #(
  parameter PERIOD = 36'd12000000000
) (
  input wire i_clock,
  input wire i_rstn,
  output reg o_tick
);
  reg [35:0] cnt_r;
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      cnt_r <= 36'h0;
      o_tick <= 1'b0;
    end else if (cnt_r >= PERIOD - 1) begin
      cnt_r <= 36'h0;
      o_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 36'h1;
      o_tick <= 1'b0;
    end
  end
endmodule

// file: rtl/auto_low_limit_adjust_zone.v
`timescale 1ns/100ps
`include "auto_low_limit_adjust_defs.vh"
// Per-zone delay timer and low-limit adjust request
module auto_low_limit_adjust_zone (
  // Clock and reset
  input wire i_clock,
  input wire i_rstn,
  // Control
  input wire i_min_tick,
  input wire i_enable,
  input wire i_hot,
  input wire [1:0] i_delay_sel,
  // Request
  output reg o_adjust
);
  reg [2:0] wait_r;
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      wait_r <= 3'h0;
      o_adjust <= 1'b0;
    end else begin
      o_adjust <= 1'b0;
      if (!i_enable) begin
        wait_r <= 3'h0;
      end else if (wait_r != 3'h0) begin
        if (i_min_tick)
          wait_r <= wait_r - 3'h1;
      end else if (i_hot) begin
        o_adjust <= 1'b1;
        wait_r <= {1'b0, i_delay_sel} + 3'h1;
      end
    end
  end
endmodule

// file: rtl/auto_low_limit_adjust_top.v
`timescale 1ns/100ps
`include "auto_low_limit_adjust_defs.vh"
// Automatic low-limit adjustment for three temperature zones
module auto_low_limit_adjust_top #(
  parameter MINUTE_CYC = 36'd12000000000
) (
  // Clock and reset
  input wire i_clock,
  input wire i_rstn,
  // Register port
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Temperature readings, zones 1..3
  input wire [7:0] i_zone1_temp,
  input wire [7:0] i_zone2_temp,
  input wire [7:0] i_zone3_temp,
  // Power good pin
  input wire i_main_power_good,
  // Low-limit adjust requests and step amounts
  output reg [2:0] o_adjust,
  output reg [3:0] o_zone1_step,
  output reg [3:0] o_zone2_step,
  output reg [3:0] o_zone3_step,
  // Interrupt
  output reg o_monitor_irq_pin_n
);
  reg [7:0] step_rem_r;
  reg [7:0] step_amb_r;
  reg [7:0] dly_rem_r;
  reg [7:0] enable_r;
  reg [2:0] status_r;
  reg [7:0] rsv_rw_r;
  reg [7:0] top1_r;
  reg [7:0] top2_r;
  reg [7:0] top3_r;
  reg lock_r;
  reg gie_r;
  reg pg_s1_r;
  reg pg_s2_r;
  reg pg_d_r;
  reg [7:0] rd_nxt;
  reg [2:0] status_nxt;
  wire min_tick;
  wire [2:0] hot;
  wire [2:0] adj;
  wire pg_rise;
  wire wr_ok;

  function [3:0] step_deg;
    input [1:0] sel;
    begin
      step_deg = {1'b0, sel, 1'b0} + 4'h2;
    end
  endfunction

  assign hot[`AUTO_LOW_LIMIT_ADJUST_ST_Z1] = i_zone1_temp >= top1_r;
  assign hot[`AUTO_LOW_LIMIT_ADJUST_ST_Z2] = i_zone2_temp >= top2_r;
  assign hot[`AUTO_LOW_LIMIT_ADJUST_ST_Z3] = i_zone3_temp >= top3_r;
  assign pg_rise = pg_s2_r & ~pg_d_r;
  assign wr_ok = i_wr & ~lock_r;

  auto_low_limit_adjust_tick #(.PERIOD(MINUTE_CYC)) u_tick (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .o_tick(min_tick)
  );

  auto_low_limit_adjust_zone u_z1 (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_min_tick(min_tick),
    .i_enable(enable_r[`AUTO_LOW_LIMIT_ADJUST_EN_Z1]),
    .i_hot(hot[`AUTO_LOW_LIMIT_ADJUST_ST_Z1]),
    .i_delay_sel(dly_rem_r[7:6]),
    .o_adjust(adj[`AUTO_LOW_LIMIT_ADJUST_ST_Z1])
  );
  auto_low_limit_adjust_zone u_z2 (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_min_tick(min_tick),
    .i_enable(enable_r[`AUTO_LOW_LIMIT_ADJUST_EN_Z2]),
    .i_hot(hot[`AUTO_LOW_LIMIT_ADJUST_ST_Z2]),
    .i_delay_sel(step_amb_r[1:0]),
    .o_adjust(adj[`AUTO_LOW_LIMIT_ADJUST_ST_Z2])
  );
  auto_low_limit_adjust_zone u_z3 (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_min_tick(min_tick),
    .i_enable(enable_r[`AUTO_LOW_LIMIT_ADJUST_EN_Z3]),
    .i_hot(hot[`AUTO_LOW_LIMIT_ADJUST_ST_Z3]),
    .i_delay_sel(dly_rem_r[5:4]),
    .o_adjust(adj[`AUTO_LOW_LIMIT_ADJUST_ST_Z3])
  );

  // Power good is a pin: two flops before use
  // Reset to the idle high level so leaving reset is not taken as a rise
  always @(posedge i_clock) begin
    if (!i_rstn) begin
      pg_s1_r <= 1'b1;
      pg_s2_r <= 1'b1;
      pg_d_r <= 1'b1;
    end else begin
      pg_s1_r <= i_main_power_good;
      pg_s2_r <= pg_s1_r;
      pg_d_r <= pg_s2_r;
    end
  end

  // Set wins over the write-one clear; a hot zone is cleared only by a power-good rise
  always @* begin
    status_nxt = status_r;
    if (i_wr && i_addr == `AUTO_LOW_LIMIT_ADJUST_ADDR_STATUS)
      status_nxt = status_r & ~(i_wdata[2:0] & ~hot);
    status_nxt = status_nxt | hot;
    if (pg_rise)
      status_nxt = 3'h0;
  end

  always @* begin
    case (i_addr)
      `AUTO_LOW_LIMIT_ADJUST_ADDR_STEP_REM: rd_nxt = {step_rem_r[7:4], 4'h0};
      `AUTO_LOW_LIMIT_ADJUST_ADDR_STEP_AMB: rd_nxt = {2'b00, step_amb_r[5:4], 2'b00, step_amb_r[1:0]};
      `AUTO_LOW_LIMIT_ADJUST_ADDR_DLY_REM: rd_nxt = {dly_rem_r[7:4], 4'h0};
      `AUTO_LOW_LIMIT_ADJUST_ADDR_ENABLE: rd_nxt = {4'h0, enable_r[3:0]};
      `AUTO_LOW_LIMIT_ADJUST_ADDR_STATUS: rd_nxt = {5'h00, status_r};
      `AUTO_LOW_LIMIT_ADJUST_ADDR_RSV_RW: rd_nxt = rsv_rw_r;
      `AUTO_LOW_LIMIT_ADJUST_ADDR_TOP_Z1: rd_nxt = top1_r;
      `AUTO_LOW_LIMIT_ADJUST_ADDR_TOP_Z2: rd_nxt = top2_r;
      `AUTO_LOW_LIMIT_ADJUST_ADDR_TOP_Z3: rd_nxt = top3_r;
      `AUTO_LOW_LIMIT_ADJUST_ADDR_CTRL: rd_nxt = {6'h00, gie_r, lock_r};
      default: rd_nxt = 8'h00;
    endcase
  end

  always @(posedge i_clock) begin
    if (!i_rstn) begin
      step_rem_r <= 8'h00;
      step_amb_r <= 8'h00;
      dly_rem_r <= 8'h00;
      enable_r <= 8'h00;
      status_r <= 3'h0;
      rsv_rw_r <= `AUTO_LOW_LIMIT_ADJUST_RST_RSV_RW;
      top1_r <= `AUTO_LOW_LIMIT_ADJUST_RST_TOP;
      top2_r <= `AUTO_LOW_LIMIT_ADJUST_RST_TOP;
      top3_r <= `AUTO_LOW_LIMIT_ADJUST_RST_TOP;
      lock_r <= 1'b0;
      gie_r <= 1'b0;
      o_rdata <= 8'h00;
      o_adjust <= 3'h0;
      o_zone1_step <= 4'h2;
      o_zone2_step <= 4'h2;
      o_zone3_step <= 4'h2;
      o_monitor_irq_pin_n <= 1'b1;
    end else begin
      status_r <= status_nxt;
      o_rdata <= i_rd ? rd_nxt : 8'h00;
      o_adjust <= adj;
      o_zone1_step <= step_deg(step_rem_r[7:6]);
      o_zone3_step <= step_deg(step_rem_r[5:4]);
      o_zone2_step <= step_deg(step_amb_r[5:4]);
      o_monitor_irq_pin_n <= ~(|status_r & enable_r[`AUTO_LOW_LIMIT_ADJUST_EN_TOPINT] & gie_r);
      if (pg_rise) begin
        top1_r <= `AUTO_LOW_LIMIT_ADJUST_RST_TOP;
        top2_r <= `AUTO_LOW_LIMIT_ADJUST_RST_TOP;
        top3_r <= `AUTO_LOW_LIMIT_ADJUST_RST_TOP;
      end
      if (i_wr) begin
        case (i_addr)
          `AUTO_LOW_LIMIT_ADJUST_ADDR_CTRL: begin
            // Lock is sticky until reset
            lock_r <= lock_r | i_wdata[`AUTO_LOW_LIMIT_ADJUST_CTRL_LOCK];
            gie_r <= i_wdata[`AUTO_LOW_LIMIT_ADJUST_CTRL_GIE];
          end
          `AUTO_LOW_LIMIT_ADJUST_ADDR_RSV_RW: rsv_rw_r <= i_wdata;
          default: begin
          end
        endcase
      end
      if (wr_ok) begin
        case (i_addr)
          `AUTO_LOW_LIMIT_ADJUST_ADDR_STEP_REM: step_rem_r <= {i_wdata[7:4], 4'h0};
          `AUTO_LOW_LIMIT_ADJUST_ADDR_STEP_AMB: step_amb_r <= {2'b00, i_wdata[5:4], 2'b00, i_wdata[1:0]};
          `AUTO_LOW_LIMIT_ADJUST_ADDR_DLY_REM: dly_rem_r <= {i_wdata[7:4], 4'h0};
          `AUTO_LOW_LIMIT_ADJUST_ADDR_ENABLE: enable_r <= {4'h0, i_wdata[3:0]};
          `AUTO_LOW_LIMIT_ADJUST_ADDR_TOP_Z1: top1_r <= i_wdata;
          `AUTO_LOW_LIMIT_ADJUST_ADDR_TOP_Z2: top2_r <= i_wdata;
          `AUTO_LOW_LIMIT_ADJUST_ADDR_TOP_Z3: top3_r <= i_wdata;
          default: begin
          end
        endcase
      end
    end
  end
endmodule

// file: testbench/auto_low_limit_adjust_top_asserts.sv
`timescale 1ns/100ps
module auto_low_limit_adjust_top_asserts #(
  parameter MINUTE_CYC = 36'd12000000000
) (
  // Clock, reset and bus
  input wire i_clock,
  input wire i_rstn,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  // Zones and outputs
  input wire [7:0] i_zone1_temp,
  input wire [7:0] i_zone2_temp,
  input wire [7:0] i_zone3_temp,
  input wire i_main_power_good,
  input wire [2:0] o_adjust,
  input wire [3:0] o_zone1_step,
  input wire [3:0] o_zone2_step,
  input wire [3:0] o_zone3_step,
  input wire o_monitor_irq_pin_n
);
  wire wr_step = i_wr && i_addr == 8'hb4;
  wire gie_off = i_wr && i_addr == 8'hf0 && !i_wdata[1];
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("stray read data");
  a_adjust_pulse: assert property (o_adjust != 3'h0 |=> o_adjust == 3'h0) else $error("long adjust");
  a_step_legal: assert property (o_zone1_step inside {4'h2, 4'h4, 4'h6, 4'h8}) else $error("bad step");
  // Two cycles of slack cover the register and the output flop
  a_step_steady: assert property (!$past(wr_step) && !$past(wr_step, 2) |-> $stable(o_zone1_step))
    else $error("step moved");
  a_irq_gie_off: assert property (gie_off ##1 !i_wr |=> o_monitor_irq_pin_n) else $error("irq kept");
  a_reset_state: assert property ($rose(i_rstn) |-> o_adjust == 3'h0 && o_monitor_irq_pin_n)
    else $error("bad reset state");
  a_status_rsv: assert property ($past(i_rd) && $past(i_addr) == 8'hb8 |-> o_rdata[7:3] == 5'h00)
    else $error("status spare bits");
  a_rsv_ro: assert property ($past(i_rd) && $past(i_addr) == 8'hbb |-> o_rdata == 8'h00) else $error("bb set");
  c_adjust: cover property (o_adjust[1]);
  c_irq: cover property ($fell(o_monitor_irq_pin_n));
  c_lock: cover property (i_wr && i_addr == 8'hf0 && i_wdata[0]);
endmodule
bind auto_low_limit_adjust_top auto_low_limit_adjust_top_asserts #(.MINUTE_CYC(MINUTE_CYC)) u_chk (.i_clock(i_clock), .i_rstn(i_rstn),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_zone1_temp(i_zone1_temp),
  .i_zone2_temp(i_zone2_temp), .i_zone3_temp(i_zone3_temp), .i_main_power_good(i_main_power_good),
  .o_adjust(o_adjust), .o_zone1_step(o_zone1_step), .o_zone2_step(o_zone2_step), .o_zone3_step(o_zone3_step),
  .o_monitor_irq_pin_n(o_monitor_irq_pin_n));

// file: testbench/auto_low_limit_adjust_top_tb_top.sv
`timescale 1ns/100ps
module auto_low_limit_adjust_top_tb_top;
  logic clk, rstn, wr, rd, pg, irqn;
  logic [7:0] addr, wd, rdat, z1, z2, z3;
  logic [2:0] adj;
  logic [3:0] s1, s2, s3;
  int mismatches, samples_checked;
  // Short minute keeps the delay scenario within a few hundred cycles
  auto_low_limit_adjust_top #(.MINUTE_CYC(36'd20)) i_dut (.i_clock(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdat), .i_zone1_temp(z1), .i_zone2_temp(z2), .i_zone3_temp(z3), .i_main_power_good(pg),
    .o_adjust(adj), .o_zone1_step(s1), .o_zone2_step(s2), .o_zone3_step(s3), .o_monitor_irq_pin_n(irqn));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdat, e);
  endtask
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task t_reset;
    logic [7:0] ra [11];
    ra = '{8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hb8, 8'hba, 8'hbb, 8'hae, 8'haf, 8'hb3, 8'hc0};
    foreach (ra[i]) rdchk(ra[i], i == 5 ? 8'h03 : (i > 6 && i < 10) ? 8'h2d : 8'h00);
    chk({s1, s2}, 8'h22);
    chk({s3, 3'h0, irqn}, 8'h21);
    $display("t_reset done");
  endtask
  task t_step;
    logic [2:0] s;
    logic [3:0] e;
    for (s = 0; s < 4; s++) begin
      wr8(8'hb4, {s[1:0], s[1:0], 4'hf});
      wr8(8'hb5, {2'h3, s[1:0], 4'hf});
      rdchk(8'hb4, {s[1:0], s[1:0], 4'h0});
      rdchk(8'hb5, {2'h0, s[1:0], 4'h3});
      e = {s[1:0] + 3'd1, 1'b0};
      chk({s1, s3}, {e, e});
      chk({4'h0, s2}, {4'h0, e});
    end
    $display("t_step done");
  endtask
  task t_adjust;
    int n, g, gmin, gmax, other;
    wr8(8'hae, 8'h30);
    wr8(8'hb6, 8'h4f);
    rdchk(8'hb6, 8'h40);
    wr8(8'hb7, 8'h04);
    z1 <= 8'h30;
    z3 <= 8'hff;
    n = 0;
    g = 0;
    gmin = 999;
    gmax = 0;
    other = 0;
    repeat (400) begin
      @(posedge clk);
      #1 g++;
      if (adj[1] === 1'b1) begin
        if (n > 0 && g < gmin) gmin = g;
        if (n > 0 && g > gmax) gmax = g;
        n++;
        g = 0;
      end
      if (adj[0] !== 1'b0 || adj[2] !== 1'b0) other++;
    end
    chk(8'(n > 7), 8'h01);
    chk(8'(gmin > 20), 8'h01);
    chk(8'(gmax < 45), 8'h01);
    chk(8'(other), 8'h00);
    $display("t_adjust done");
  endtask
  task t_status;
    rdchk(8'hb8, 8'h06);
    wr8(8'hf0, 8'h02);
    settle;
    chk(8'(irqn), 8'h01);
    wr8(8'hb7, 8'h05);
    settle;
    chk(8'(irqn), 8'h00);
    wr8(8'hf0, 8'h00);
    settle;
    chk(8'(irqn), 8'h01);
    wr8(8'hf0, 8'h02);
    wr8(8'hb8, 8'h06);
    rdchk(8'hb8, 8'h06);
    @(posedge clk);
    z3 <= 8'h00;
    wr8(8'hb8, 8'h00);
    rdchk(8'hb8, 8'h06);
    wr8(8'hb8, 8'h04);
    rdchk(8'hb8, 8'h02);
    @(posedge clk);
    z1 <= 8'h00;
    rdchk(8'hb8, 8'h02);
    @(posedge clk);
    pg <= 0;
    repeat (4) @(posedge clk);
    pg <= 1;
    repeat (6) @(posedge clk);
    rdchk(8'hb8, 8'h00);
    rdchk(8'hae, 8'h2d);
    settle;
    chk(8'(irqn), 8'h01);
    $display("t_status done");
  endtask
  task t_lock;
    wr8(8'hf0, 8'h03);
    wr8(8'hb4, 8'h00);
    wr8(8'hb7, 8'h00);
    wr8(8'hae, 8'h11);
    rdchk(8'hb4, 8'hf0);
    rdchk(8'hb7, 8'h05);
    rdchk(8'hae, 8'h2d);
    chk({4'h0, s1}, 8'h08);
    wr8(8'hba, 8'h03);
    rdchk(8'hba, 8'h03);
    $display("t_lock done");
  endtask
  task conclude;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    {wr, rd, rstn, addr, wd, z1, z2, z3} = 0;
    pg = 1;
    repeat (4) @(posedge clk);
    rstn <= 1;
    t_reset;
    t_step;
    t_adjust;
    t_status;
    t_lock;
    conclude;
  end
  initial begin
    #100000;
    mismatches++;
    conclude;
  end
endmodule
